// ### hw/lbce_executor.sv
// per-scan executor of bit-control, lock and jump ladder instructions
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module lbce_executor #(
  parameter int BIT_AW  = 12,
  parameter int PROG_AW = 10
) (
  input  wire logic                        core_clk,
  input  wire logic                        nrst,
  input  wire logic                        multi_jump0_en,
  input  wire logic                        scan_start,
  input  wire logic                        instr_valid,
  input  wire logic [lbce_pkg::FUNC_W-1:0] instr_code,
  input  wire logic [PROG_AW-1:0]          instr_pc,
  input  wire logic [BIT_AW-1:0]           instr_bit,
  input  wire logic [lbce_pkg::JNUM_W-1:0] instr_jnum,
  input  wire logic                        cond_set,
  input  wire logic                        cond_reset,
  input  wire logic                        cmp_result,
  input  wire logic                        at_right_bar,
  input  wire logic [BIT_AW-1:0]           rd_addr,
  output logic                             rd_data_q,
  output logic                             wr_en_q,
  output logic [BIT_AW-1:0]                wr_addr_q,
  output logic                             wr_data_q,
  output logic                             cond_out_q,
  output logic                             skip_q,
  output logic                             lock_q,
  output logic                             jump_back_q,
  output logic [lbce_pkg::JNUM_W-1:0]      jump_back_num_q,
  output logic                             format_err_q
);
  import lbce_pkg::*;

  localparam int BIT_COUNT  = 1 << BIT_AW;
  localparam int PROG_COUNT = 1 << PROG_AW;

  if (BIT_AW < 1 || BIT_AW > 20 || PROG_AW < 1 || PROG_AW > 20) begin : g_chk
    $error("lbce_executor: address widths out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // storage
  logic                 bit_mem   [BIT_COUNT];
  logic                 hist_mem  [PROG_COUNT];
  logic                 jme_stamp [JNUM_COUNT];
  logic                 par_q;
  lbce_state_type       state_q;
  logic [JNUM_W-1:0]    skip_num_q;

  //////////////////////////////////////////////////////////////////////////////
  // decode
  logic is_bitctl;
  logic is_inter;
  logic run_valid;
  logic cond_eff;
  logic hist_prev;
  logic jnum_ok;
  logic jme_seen;
  logic jump_multi;
  logic jump_taken;
  logic skip_end;

  always_comb begin
    is_bitctl = (instr_code == FC_OUTPUT) || (instr_code == FC_OUTPUT_INV) ||
                (instr_code == FC_RISING_PULSE) ||
                (instr_code == FC_FALLING_PULSE) ||
                (instr_code == FC_SET_BIT) || (instr_code == FC_RESET_BIT) ||
                (instr_code == FC_LATCH);
    is_inter  = (instr_code == FC_LOGIC_NOT) ||
                (instr_code == FC_WORD_COMPARE) ||
                (instr_code == FC_DWORD_COMPARE) ||
                (instr_code == FC_EQUALITY_TEST);
  end

  assign run_valid  = instr_valid && !scan_start && (state_q == ST_RUN);
  assign cond_eff   = cond_set && !lock_q;
  assign hist_prev  = hist_mem[instr_pc];
  assign jnum_ok    = 32'(instr_jnum) < JNUM_COUNT;
  assign jme_seen   = jnum_ok && (jme_stamp[instr_jnum] == par_q);
  assign jump_multi = multi_jump0_en && (instr_jnum == JNUM_MULTI);
  assign jump_taken = run_valid && (instr_code == FC_JUMP_START) &&
                      !cond_eff && jnum_ok;
  assign skip_end   = instr_valid && !scan_start && (state_q == ST_SKIP) &&
                      (instr_code == FC_JUMP_END) &&
                      (instr_jnum == skip_num_q);

  //////////////////////////////////////////////////////////////////////////////
  // jump sequencing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= ST_RUN;
      skip_num_q <= JNUM_MULTI;
    end else if (scan_start) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          // multi 0000 always goes forward to the next end
          if (jump_taken && (jump_multi || !jme_seen)) begin
            state_q    <= ST_SKIP;
            skip_num_q <= instr_jnum;
          end
        end
        ST_SKIP: begin
          // nothing inside but jump-end stamping is evaluated until the end arrives
          if (skip_end) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // first end already passed: sequencer must rewind to it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      jump_back_q     <= 1'b0;
      jump_back_num_q <= JNUM_MULTI;
    end else begin
      jump_back_q <= jump_taken && !jump_multi && jme_seen;
      if (jump_taken) begin
        jump_back_num_q <= instr_jnum;
      end
    end
  end

  // scan parity marks which ends were passed in this scan
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      par_q <= RST_PAR;
    end else if (scan_start) begin
      par_q <= !par_q;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < JNUM_COUNT; i++) begin
        jme_stamp[i] <= RST_PAR; // first scan flips parity away
      end
    end else if (instr_valid && !scan_start &&
                 (instr_code == FC_JUMP_END) && jnum_ok) begin
      jme_stamp[instr_jnum] <= par_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // section lock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lock_q <= 1'b0;
    end else if (scan_start) begin
      lock_q <= 1'b0;
    end else if (run_valid && instr_code == FC_SECTION_LOCK) begin
      lock_q <= lock_q || !cond_set;
    end else if (run_valid && instr_code == FC_SECTION_CLEAR) begin
      lock_q <= 1'b0;
    end
  end

  assign skip_q = (state_q == ST_SKIP);

  //////////////////////////////////////////////////////////////////////////////
  // bit control
  logic wr_en_d;
  logic wr_data_d;

  always_comb begin
    wr_en_d   = 1'b0;
    wr_data_d = 1'b0;
    if (run_valid) begin
      case (instr_code)
        FC_OUTPUT: begin
          wr_en_d   = 1'b1;
          wr_data_d = cond_eff;
        end
        FC_OUTPUT_INV: begin
          wr_en_d   = 1'b1;
          wr_data_d = !cond_eff;
        end
        FC_RISING_PULSE: begin
          wr_en_d   = 1'b1;
          wr_data_d = cond_eff && !hist_prev;
        end
        FC_FALLING_PULSE: begin
          wr_en_d   = 1'b1;
          wr_data_d = !cond_eff && hist_prev;
        end
        FC_SET_BIT: begin
          wr_en_d   = cond_eff;
          wr_data_d = 1'b1;
        end
        FC_RESET_BIT: begin
          wr_en_d   = cond_eff;
          wr_data_d = 1'b0;
        end
        FC_LATCH: begin
          // set line then reset line, both ignored under lock
          wr_en_d   = !lock_q && (cond_set || cond_reset);
          wr_data_d = !cond_reset;
        end
        default: wr_en_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < PROG_COUNT; i++) begin
        hist_mem[i] <= RST_HIST;
      end
    end else if (run_valid && (instr_code == FC_RISING_PULSE ||
                               instr_code == FC_FALLING_PULSE)) begin
      hist_mem[instr_pc] <= cond_eff;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < BIT_COUNT; i++) begin
        bit_mem[i] <= RST_BIT;
      end
    end else if (wr_en_d) begin
      bit_mem[instr_bit] <= wr_data_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_en_q   <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= RST_BIT;
      rd_data_q <= RST_BIT;
    end else begin
      wr_en_q   <= wr_en_d;
      wr_addr_q <= instr_bit;
      wr_data_q <= wr_data_d;
      rd_data_q <= bit_mem[rd_addr];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // intermediate result and placement check
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cond_out_q   <= 1'b0;
      format_err_q <= 1'b0;
    end else begin
      if (run_valid && instr_code == FC_LOGIC_NOT) begin
        cond_out_q <= !cond_set;
      end else if (run_valid && is_inter) begin
        cond_out_q <= cond_set && cmp_result;
      end
      format_err_q <= run_valid &&
                      ((is_inter && at_right_bar) ||
                       (is_bitctl && !at_right_bar) ||
                       ((instr_code == FC_JUMP_START) && !jnum_ok));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_exec(logic [FUNC_W-1:0] code);
    run_valid && instr_code == code;
  endsequence

  sequence s_wrote(logic v);
    ##1 wr_en_q && wr_data_q == v;
  endsequence

  a_rise_pulse: assert property (
    s_exec(FC_RISING_PULSE) and (cond_eff && !hist_prev) |-> s_wrote(1'b1))
    else $error("rising pulse not produced");
  a_fall_pulse: assert property (
    s_exec(FC_FALLING_PULSE) and (!cond_eff && hist_prev) |-> s_wrote(1'b1))
    else $error("falling pulse not produced");
  a_pulse_drop: assert property (
    s_exec(FC_RISING_PULSE) and hist_prev |-> s_wrote(1'b0))
    else $error("pulse bit not turned off");
  a_skip_nowrite: assert property (
    skip_q && instr_valid |-> ##1 !wr_en_q)
    else $error("write inside skipped region");
  a_set_idle: assert property (
    s_exec(FC_SET_BIT) and !cond_eff |-> ##1 !wr_en_q)
    else $error("set acted with condition off");
  a_latch_prio: assert property (
    s_exec(FC_LATCH) and (!lock_q && cond_reset) |-> s_wrote(1'b0))
    else $error("latch reset line lost");
  a_latch_lock: assert property (
    s_exec(FC_LATCH) and lock_q |-> ##1 !wr_en_q)
    else $error("latch changed under lock");
  a_out_locked: assert property (
    s_exec(FC_OUTPUT) and lock_q |-> s_wrote(1'b0))
    else $error("output kept on under lock");
  a_jump0_multi: assert property (
    jump_taken && jump_multi |-> ##1 skip_q && !jump_back_q)
    else $error("multi 0000 jump not forward");
  a_skip_leave: assert property (
    skip_end |-> ##1 !skip_q)
    else $error("skip did not end at jump end");
  a_not_result: assert property (
    s_exec(FC_LOGIC_NOT) |-> ##1 cond_out_q == !$past(cond_set))
    else $error("negation result wrong");

endmodule

// ### inc/lbce_pkg.sv
// shared constants and types of the ladder bit-control executor
package lbce_pkg;

  localparam int FUNC_W = 10;
  localparam int JNUM_W = 10;

  // function codes, decimal codes written in hex
  localparam logic [FUNC_W-1:0] FC_OUTPUT        = 10'h001;
  localparam logic [FUNC_W-1:0] FC_OUTPUT_INV    = 10'h3FE;
  localparam logic [FUNC_W-1:0] FC_SECTION_LOCK  = 10'h002;
  localparam logic [FUNC_W-1:0] FC_SECTION_CLEAR = 10'h003;
  localparam logic [FUNC_W-1:0] FC_JUMP_START    = 10'h004;
  localparam logic [FUNC_W-1:0] FC_JUMP_END      = 10'h005;
  localparam logic [FUNC_W-1:0] FC_LOGIC_NOT     = 10'h00A;
  localparam logic [FUNC_W-1:0] FC_LATCH         = 10'h00B;
  localparam logic [FUNC_W-1:0] FC_RISING_PULSE  = 10'h00D;
  localparam logic [FUNC_W-1:0] FC_FALLING_PULSE = 10'h00E;
  localparam logic [FUNC_W-1:0] FC_SET_BIT       = 10'h00F;
  localparam logic [FUNC_W-1:0] FC_RESET_BIT     = 10'h010;
  localparam logic [FUNC_W-1:0] FC_WORD_COMPARE  = 10'h014;
  localparam logic [FUNC_W-1:0] FC_DWORD_COMPARE = 10'h015;
  localparam logic [FUNC_W-1:0] FC_EQUALITY_TEST = 10'h019;

  // jump number with optional multiple use
  localparam logic [JNUM_W-1:0] JNUM_MULTI = 10'h000;
  localparam int JNUM_COUNT = 1000;

  // reset values
  localparam logic RST_BIT  = 1'b0;
  localparam logic RST_HIST = 1'b0;
  localparam logic RST_PAR  = 1'b0;

  typedef enum logic {
    ST_RUN,
    ST_SKIP
  } lbce_state_type;

endpackage

// ### test/lbce_executor_test.sv
// self-checking bench of the ladder bit-control executor
`timescale 1ns/1ps
module lbce_executor_test;
  import lbce_pkg::*;

  typedef struct packed {
    logic [9:0]  code;
    logic [11:0] bit_a;
    logic [3:0]  f;
    logic [2:0]  k;
    logic        e;
  } lbce_row_type;

  localparam int WDOG_CYCLES = 2000;
  // flags: cond_set, cond_reset, cmp_result, at_right_bar
  localparam lbce_row_type ROWS [22] = '{
    '{FC_RISING_PULSE,  12'h005, 4'h9, 3'h1, 1'b1},
    '{FC_RISING_PULSE,  12'h005, 4'h9, 3'h1, 1'b0},
    '{FC_FALLING_PULSE, 12'h006, 4'h9, 3'h1, 1'b0},
    '{FC_FALLING_PULSE, 12'h006, 4'h1, 3'h1, 1'b1},
    '{FC_FALLING_PULSE, 12'h006, 4'h1, 3'h1, 1'b0},
    '{FC_SET_BIT,       12'h007, 4'h1, 3'h0, 1'b0},
    '{FC_SET_BIT,       12'h007, 4'h9, 3'h1, 1'b1},
    '{FC_RESET_BIT,     12'h007, 4'h1, 3'h0, 1'b0},
    '{FC_RESET_BIT,     12'h007, 4'h9, 3'h1, 1'b0},
    '{FC_LATCH,         12'h008, 4'h9, 3'h1, 1'b1},
    '{FC_LATCH,         12'h008, 4'h1, 3'h0, 1'b0},
    '{FC_LATCH,         12'h008, 4'h5, 3'h1, 1'b0},
    '{FC_LATCH,         12'h008, 4'hD, 3'h1, 1'b0},
    '{FC_LATCH,         12'h008, 4'h9, 3'h1, 1'b1},
    '{FC_OUTPUT,        12'h009, 4'h9, 3'h1, 1'b1},
    '{FC_OUTPUT_INV,    12'h009, 4'h9, 3'h1, 1'b0},
    '{FC_WORD_COMPARE,  12'h000, 4'hA, 3'h3, 1'b1},
    '{FC_EQUALITY_TEST, 12'h000, 4'h8, 3'h3, 1'b0},
    '{FC_DWORD_COMPARE, 12'h000, 4'hA, 3'h3, 1'b1},
    '{FC_LOGIC_NOT,     12'h000, 4'h0, 3'h3, 1'b1},
    '{FC_LOGIC_NOT,     12'h000, 4'h8, 3'h3, 1'b0},
    '{FC_WORD_COMPARE,  12'h000, 4'h8, 3'h3, 1'b0}
  };
  localparam logic [9:0] CODES [9] = '{FC_LATCH, FC_RISING_PULSE,
    FC_FALLING_PULSE, FC_SET_BIT, FC_RESET_BIT, FC_LOGIC_NOT,
    FC_WORD_COMPARE, FC_DWORD_COMPARE, FC_EQUALITY_TEST};
  localparam int DEC [9] = '{11, 13, 14, 15, 16, 10, 20, 21, 25};

  logic        core_clk, nrst, multi_jump0_en, scan_start, instr_valid;
  logic        cond_set, cond_reset, cmp_result, at_right_bar;
  logic [9:0]  instr_code, instr_pc, instr_jnum, jump_back_num_q;
  logic [11:0] instr_bit, rd_addr, wr_addr_q;
  logic        rd_data_q, wr_en_q, wr_data_q, cond_out_q, skip_q, lock_q;
  logic        jump_back_q, format_err_q;
  int          fails, checked;

  lbce_prog_model u_lbce_prog_model (.core_clk(core_clk),
    .multi_jump0_en(multi_jump0_en), .scan_start(scan_start),
    .instr_valid(instr_valid), .instr_code(instr_code),
    .instr_pc(instr_pc), .instr_bit(instr_bit), .instr_jnum(instr_jnum),
    .cond_set(cond_set), .cond_reset(cond_reset),
    .cmp_result(cmp_result), .at_right_bar(at_right_bar));

  lbce_executor u_lbce_executor (.core_clk(core_clk), .nrst(nrst),
    .multi_jump0_en(multi_jump0_en), .scan_start(scan_start),
    .instr_valid(instr_valid), .instr_code(instr_code),
    .instr_pc(instr_pc), .instr_bit(instr_bit), .instr_jnum(instr_jnum),
    .cond_set(cond_set), .cond_reset(cond_reset),
    .cmp_result(cmp_result), .at_right_bar(at_right_bar),
    .rd_addr(rd_addr), .rd_data_q(rd_data_q), .wr_en_q(wr_en_q),
    .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q),
    .cond_out_q(cond_out_q), .skip_q(skip_q), .lock_q(lock_q),
    .jump_back_q(jump_back_q), .jump_back_num_q(jump_back_num_q),
    .format_err_q(format_err_q));

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  task automatic cmp1(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input logic [9:0] code, input logic [11:0] bit_a,
                      input logic [9:0] jnum, input logic [3:0] f,
                      input logic [2:0] k, input logic e);
    u_lbce_prog_model.issue(code, bit_a, jnum, f);
    case (k)
      3'h0: cmp1(wr_en_q, 1'b0);
      3'h1: begin
        cmp1(wr_en_q, 1'b1);
        cmp1(wr_data_q, e);
        cmp1(wr_addr_q, bit_a);
      end
      3'h2: if (wr_en_q === 1'b1) cmp1(wr_data_q, e);
      3'h3: cmp1(cond_out_q, e);
      3'h4: cmp1(skip_q, e);
      3'h5: cmp1(lock_q, e);
      3'h6: cmp1(jump_back_q, e);
      default: cmp1(format_err_q, e);
    endcase
  endtask

  task automatic rd(input logic [11:0] a, input logic e);
    @(negedge core_clk);
    rd_addr = a;
    @(negedge core_clk);
    cmp1(rd_data_q, e);
  endtask

  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #(WDOG_CYCLES * 50);
    fails++;
    complete_run;
  end

  initial begin
    fails = 0;
    checked = 0;
    nrst = 1'b0;
    rd_addr = 12'h000;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    cmp1({wr_en_q, wr_data_q, skip_q, lock_q, jump_back_q, format_err_q,
          cond_out_q, rd_data_q}, 12'h000);
    $display("reset test done");
    for (int i = 0; i < 9; i++) cmp1(CODES[i], DEC[i]);
    u_lbce_prog_model.scan(1'b0);
    for (int i = 0; i < 22; i++) begin
      step(ROWS[i].code, ROWS[i].bit_a, 10'h000, ROWS[i].f,
           ROWS[i].k, ROWS[i].e);
    end
    $display("table test done");
    step(FC_SECTION_LOCK, 12'h000, 10'h000, 4'h1, 3'h5, 1'b1);
    step(FC_OUTPUT, 12'h009, 10'h000, 4'h9, 3'h1, 1'b0);
    step(FC_LATCH, 12'h008, 10'h000, 4'h9, 3'h0, 1'b0);
    step(FC_SECTION_CLEAR, 12'h000, 10'h000, 4'h1, 3'h5, 1'b0);
    rd(12'h008, 1'b1);
    step(FC_WORD_COMPARE, 12'h000, 10'h000, 4'hB, 3'h7, 1'b1);
    step(FC_SET_BIT, 12'h007, 10'h000, 4'h8, 3'h7, 1'b1);
    $display("lock and format test done");
    step(FC_RISING_PULSE, 12'h00A, 10'h000, 4'h9, 3'h1, 1'b1);
    step(FC_JUMP_START, 12'h000, 10'h005, 4'h1, 3'h4, 1'b1);
    cmp1(jump_back_num_q, 12'h005);
    step(FC_RISING_PULSE, 12'h00A, 10'h000, 4'h1, 3'h0, 1'b0);
    step(FC_JUMP_END, 12'h000, 10'h005, 4'h1, 3'h4, 1'b0);
    rd(12'h00A, 1'b1);
    step(FC_RISING_PULSE, 12'h00A, 10'h000, 4'h9, 3'h1, 1'b0);
    $display("jump test done");
    u_lbce_prog_model.scan(1'b1);
    step(FC_JUMP_END, 12'h000, 10'h000, 4'h1, 3'h4, 1'b0);
    step(FC_JUMP_START, 12'h000, 10'h000, 4'h1, 3'h4, 1'b1);
    step(FC_SET_BIT, 12'h00C, 10'h000, 4'h9, 3'h0, 1'b0);
    step(FC_JUMP_END, 12'h000, 10'h000, 4'h1, 3'h4, 1'b0);
    rd(12'h00C, 1'b0);
    u_lbce_prog_model.scan(1'b0);
    step(FC_JUMP_END, 12'h000, 10'h000, 4'h1, 3'h4, 1'b0);
    step(FC_JUMP_START, 12'h000, 10'h000, 4'h1, 3'h6, 1'b1);
    cmp1(skip_q, 1'b0);
    $display("jump zero test done");
    complete_run;
  end
endmodule

// ### test/lbce_prog_model.sv
// partner model: ladder program sequencer feeding one instruction at a time
`timescale 1ns/1ps
module lbce_prog_model (
  input  wire logic              core_clk,
  output logic                   multi_jump0_en,
  output logic                   scan_start,
  output logic                   instr_valid,
  output logic [lbce_pkg::FUNC_W-1:0] instr_code,
  output logic [9:0]             instr_pc,
  output logic [11:0]            instr_bit,
  output logic [lbce_pkg::JNUM_W-1:0] instr_jnum,
  output logic                   cond_set,
  output logic                   cond_reset,
  output logic                   cmp_result,
  output logic                   at_right_bar
);
  import lbce_pkg::*;

  initial begin
    {multi_jump0_en, scan_start, instr_valid, cond_set} = 4'h0;
    {cond_reset, cmp_result, at_right_bar} = 3'h0;
    {instr_code, instr_pc, instr_bit, instr_jnum} = '0;
  end

  task automatic scan(input logic multi);
    @(negedge core_clk);
    multi_jump0_en = multi;
    scan_start = 1'b1;
    @(negedge core_clk);
    scan_start = 1'b0;
  endtask

  // caller keeps 0000 starts and ends alternating
  // work bits only from unallocated addresses
  task automatic issue(input logic [9:0] code, input logic [11:0] bit_a,
                       input logic [9:0] jnum, input logic [3:0] f);
    @(negedge core_clk);
    instr_code = code;
    instr_pc = bit_a[9:0];
    instr_bit = bit_a;
    instr_jnum = jnum;
    {cond_set, cond_reset} = f[3:2];
    cmp_result = f[1];
    at_right_bar = f[0];
    instr_valid = 1'b1;
    @(negedge core_clk);
    instr_valid = 1'b0;
    // released code, bit, condition and compare lines show no stale value; pc, jnum, right-bar keep theirs
    instr_code = ~code;
    instr_bit = ~bit_a;
    {cond_set, cond_reset, cmp_result} = ~f[3:1];
  endtask
endmodule
